// file: hw/hbs_top.sv
module hbs_top #(
	parameter int TICK_CYCLES = hbs_pkg::TICK_CYCLES
) (
	input  wire logic                           clk,
	input  wire logic                           rst,
	input  wire logic                           on_cmd,
	input  wire logic                           force_release_in,
	input  wire logic                           force_apply_in,
	input  wire logic                           speed_ctrl_enable_in,
	input  wire logic                           brake_present_in,
	input  wire logic                           first_commission,
	input  wire logic                           fault_ack,
	input  wire logic [hbs_pkg::CFG_W-1:0]      brake_config,
	input  wire logic [hbs_pkg::TIME_W-1:0]     brake_release_time,
	input  wire logic [hbs_pkg::TIME_W-1:0]     brake_closing_time,
	input  wire logic [hbs_pkg::SPEED_W-1:0]    standstill_threshold,
	input  wire logic [hbs_pkg::TIME_W-1:0]     standstill_monitor_time,
	input  wire logic [hbs_pkg::TIME_W-1:0]     pulse_suppress_delay,
	input  wire logic signed [hbs_pkg::SPEED_W-1:0] speed_setpoint,
	input  wire logic signed [hbs_pkg::SPEED_W-1:0] speed_actual,
	output logic                                brake_out,
	output logic                                pulse_enable,
	output logic                                accel_enable,
	output logic                                brake_detected_fault,
	output logic [hbs_pkg::CFG_W-1:0]           config_eff,
	output logic [hbs_pkg::STATUS_W-1:0]        brake_status
);
	// ==========================================================
	// Input synchronisers for pins
	logic [7:0] s1_reg;
	logic [7:0] s2_reg;
	logic [7:0] pins;
	assign pins = {on_cmd, force_release_in, force_apply_in, speed_ctrl_enable_in,
		brake_present_in, first_commission, fault_ack, 1'b0};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= 8'h00;
			s2_reg <= 8'h00;
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
		end
	end
	logic on_s, frel_s, fapp_s, sen_s, pres_s, fc_s, ack_s;
	assign {on_s, frel_s, fapp_s, sen_s, pres_s, fc_s, ack_s} = s2_reg[7:1];

	function automatic logic [hbs_pkg::SPEED_W-1:0] mag(input logic signed [hbs_pkg::SPEED_W-1:0] v);
		mag = v[hbs_pkg::SPEED_W-1] ? (~v + 16'h0001) : v;
	endfunction

	// ==========================================================
	// Millisecond tick
	logic [hbs_pkg::TICK_CNT_W-1:0] div_reg;
	logic [hbs_pkg::TICK_CNT_W-1:0] div_next;
	logic                           tick;
	always_comb begin
		tick = (div_reg == hbs_pkg::TICK_CNT_W'(TICK_CYCLES - 1));
		div_next = tick ? '0 : div_reg + 17'h00001;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) div_reg <= '0;
		else div_reg <= div_next;
	end

	// ==========================================================
	// Configuration and detection fault
	logic [1:0] cfg_reg;
	logic [1:0] cfg_next;
	logic       cfg_ov_reg;
	logic       cfg_ov_next;
	logic       flt_reg;
	logic       flt_next;
	always_comb begin
		cfg_ov_next = cfg_ov_reg;
		flt_next = flt_reg;
		if (!cfg_ov_reg && fc_s && pres_s && brake_config == hbs_pkg::CFG_NONE) begin
			cfg_ov_next = 1'b1;
		end
		if (ack_s) flt_next = 1'b0;
		if (!cfg_ov_reg && fc_s && pres_s && brake_config == hbs_pkg::CFG_NONE) flt_next = 1'b1;
		cfg_next = (cfg_ov_next && brake_config == hbs_pkg::CFG_NONE) ? hbs_pkg::CFG_SEQ : brake_config;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_reg <= 2'h0;
			cfg_ov_reg <= 1'b0;
			flt_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			cfg_ov_reg <= cfg_ov_next;
			flt_reg <= flt_next;
		end
	end

	// ==========================================================
	// Standstill detection
	logic standstill;
	assign standstill = (mag(speed_setpoint) < standstill_threshold) ||
		(mag(speed_actual) < standstill_threshold);

	// ==========================================================
	// Brake sequence
	hbs_pkg::hbs_state_e st_reg, st_next;
	logic [hbs_pkg::TIME_W-1:0] t_reg, t_next;
	logic [hbs_pkg::TIME_W-1:0] ss_reg, ss_next;
	logic [hbs_pkg::TIME_W-1:0] pd_reg, pd_next;
	logic ss_run_reg, ss_run_next;
	logic brk_reg, brk_next, pe_reg, pe_next, acc_reg, acc_next, ccmd_reg, ccmd_next;
	logic has_brake, stop_req, ss_done, pd_done;
	always_comb begin
		has_brake = (cfg_reg != hbs_pkg::CFG_NONE);
		stop_req = !on_s || !sen_s || fapp_s;
		ss_done = ss_run_reg && (ss_reg >= standstill_monitor_time);
		pd_done = pd_reg >= pulse_suppress_delay;
		st_next = st_reg;
		t_next = t_reg;
		ss_next = ss_reg;
		pd_next = pd_reg;
		ss_run_next = ss_run_reg;
		unique case (st_reg)
			hbs_pkg::HBS_IDLE: begin
				t_next = '0;
				ss_run_next = 1'b0;
				ss_next = '0;
				pd_next = '0;
				if (on_s && sen_s && !fapp_s) st_next = has_brake ? hbs_pkg::HBS_OPENING : hbs_pkg::HBS_NOBRAKE;
			end
			hbs_pkg::HBS_OPENING: begin
				if (tick) t_next = t_reg + 16'h0001;
				if (stop_req) begin
					st_next = hbs_pkg::HBS_CLOSING;
					t_next = '0;
				end else if (t_reg >= brake_release_time) begin
					st_next = hbs_pkg::HBS_RUN;
				end
			end
			hbs_pkg::HBS_RUN: begin
				if (stop_req) begin
					st_next = hbs_pkg::HBS_STOPPING;
					ss_next = '0;
					pd_next = '0;
					ss_run_next = 1'b0;
				end
			end
			hbs_pkg::HBS_STOPPING: begin
				if (standstill) ss_run_next = 1'b1;
				if (tick && ss_run_reg) ss_next = ss_reg + 16'h0001;
				if (tick) pd_next = pd_reg + 16'h0001;
				if (ss_done || pd_done || fapp_s) begin
					st_next = hbs_pkg::HBS_CLOSING;
					t_next = '0;
				end
			end
			hbs_pkg::HBS_CLOSING: begin
				if (tick) t_next = t_reg + 16'h0001;
				if (t_reg >= brake_closing_time) st_next = hbs_pkg::HBS_IDLE;
			end
			hbs_pkg::HBS_NOBRAKE: begin
				if (stop_req) st_next = hbs_pkg::HBS_IDLE;
			end
			default: st_next = hbs_pkg::HBS_IDLE;
		endcase
		pe_next = (st_next != hbs_pkg::HBS_IDLE);
		acc_next = (st_next == hbs_pkg::HBS_RUN) || (st_next == hbs_pkg::HBS_STOPPING) ||
			(st_next == hbs_pkg::HBS_NOBRAKE);
		brk_next = has_brake && ((st_next == hbs_pkg::HBS_OPENING) || (st_next == hbs_pkg::HBS_RUN) ||
			(st_next == hbs_pkg::HBS_STOPPING));
		if (has_brake && frel_s) brk_next = 1'b1;
		if (fapp_s) brk_next = 1'b0;
		if (!has_brake) brk_next = 1'b0;
		// Close command is the inverse of the final brake command when a brake is configured, forced release included
		ccmd_next = has_brake && !brk_next;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= hbs_pkg::HBS_IDLE;
			t_reg <= '0;
			ss_reg <= '0;
			pd_reg <= '0;
			ss_run_reg <= 1'b0;
			brk_reg <= 1'b0;
			pe_reg <= 1'b0;
			acc_reg <= 1'b0;
			ccmd_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			t_reg <= t_next;
			ss_reg <= ss_next;
			pd_reg <= pd_next;
			ss_run_reg <= ss_run_next;
			brk_reg <= brk_next;
			pe_reg <= pe_next;
			acc_reg <= acc_next;
			ccmd_reg <= ccmd_next;
		end
	end

	// ==========================================================
	// Status word
	logic [hbs_pkg::STATUS_W-1:0] stat_reg, stat_next;
	always_comb begin
		stat_next = '0;
		stat_next[hbs_pkg::OPEN_BIT] = brk_reg;
		stat_next[hbs_pkg::CLOSE_CMD_BIT] = ccmd_reg;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) stat_reg <= '0;
		else stat_reg <= stat_next;
	end

	assign brake_out = brk_reg;
	assign pulse_enable = pe_reg;
	assign accel_enable = acc_reg;
	assign brake_detected_fault = flt_reg;
	assign config_eff = cfg_reg;
	assign brake_status = stat_reg;
endmodule

// file: inc/hbs_pkg.sv
// Overview of operation
// - The closing phase starts when the first of the standstill timer or the pulse suppress delay timer runs out.
// - The sequence runs by itself from the drive sequence control and watches for standstill within it.
// - The brake is released whenever the forced release input is high, a brake is configured and the unconditional apply input is 0.
// - The brake is applied whenever the unconditional apply input is 1, overriding all other state.
// - The brake is applied once the speed controller enable is withdrawn; from HBS_RUN it is applied after the stopping phase, as for an off command.
// - With configuration 3 the brake follows the sequence control on a free output that the user wires to a relay.
// - With configuration 0 and a brake detected during first commissioning, the configuration becomes 1 and a fault is raised until acknowledged.
// - The motor is held from accelerating until the release time has passed after the release command.
// - Output pulses are suppressed only after the closing time has passed after the close command.
// - Release and apply commands from the control unit are combined with internal state to drive the brake output.
// - Bit 12 of the brake status word shows that the brake is open.
// - Bit 13 of the brake status word carries the command to close the brake.
package hbs_pkg;
	// ==========================================================
	// Sizes and codes
	localparam int          SPEED_W        = 16;
	localparam int          TIME_W         = 16;
	localparam int          STATUS_W       = 16;
	localparam int          CFG_W          = 2;
	localparam logic [1:0]  CFG_NONE       = 2'h0;
	localparam logic [1:0]  CFG_SEQ        = 2'h1;
	localparam logic [1:0]  CFG_FREE_OUT   = 2'h3;
	localparam int          OPEN_BIT       = 12;
	localparam int          CLOSE_CMD_BIT  = 13;
	// ==========================================================
	// Timing: times are given in ms, one tick per ms
	localparam int          CLK_HZ         = 100000000;
	localparam int          TICK_MS        = 1;
	localparam int          TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
	localparam int          TICK_CNT_W     = 17;

	typedef enum logic [5:0] {
		HBS_IDLE    = 6'h01,
		HBS_OPENING = 6'h02,
		HBS_RUN     = 6'h04,
		HBS_STOPPING= 6'h08,
		HBS_CLOSING = 6'h10,
		HBS_NOBRAKE = 6'h20
	} hbs_state_e;
endpackage

// file: tb/hbs_brake_model.sv
module hbs_brake_model (
	input  wire logic clk,
	input  wire logic brake_out,
	input  wire logic fitted,
	output logic      brake_present_in,
	output logic      shoe_lifted
);
	timeunit 1ns;
	timeprecision 1ps;
	// Coil seen only when a brake is wired on the relay output
	assign brake_present_in = fitted;
	// Shoe lifts one cycle after the coil is energised
	always_ff @(posedge clk)
		shoe_lifted <= fitted & brake_out;
endmodule

// file: tb/hbs_top_sva.sv
module hbs_top_sva (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        force_release_in,
	input wire logic        force_apply_in,
	input wire logic [1:0]  brake_config,
	input wire logic        brake_out,
	input wire logic        pulse_enable,
	input wire logic        accel_enable,
	input wire logic        brake_detected_fault,
	input wire logic [1:0]  config_eff,
	input wire logic [15:0] brake_status
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Properties
	sequence s_apply_held;
		force_apply_in [*5];
	endsequence
	sequence s_release_held;
		(force_release_in && !force_apply_in && brake_config != 2'h0) [*6];
	endsequence
	apply_hold_a: assert property (s_apply_held |-> !brake_out) else $error("brake open under forced apply");
	force_open_a: assert property (s_release_held |-> brake_out) else $error("forced release ignored");
	status_open_a: assert property ($rose(brake_out) |=> brake_status[12]) else $error("open flag late");
	close_cmd_a: assert property (brake_out |=> !brake_status[13]) else $error("close flag while open");
	accel_gate_a: assert property ($rose(accel_enable) && config_eff != 2'h0 |-> brake_out) else $error("accel early");
	no_brake_a: assert property ((config_eff == 2'h0) [*3] |-> !brake_out) else $error("brake driven unconfigured");
	pulse_hold_a: assert property ($fell(brake_out) && $past(pulse_enable) && !force_apply_in |-> pulse_enable)
		else $error("pulses cut before closing");
	fault_cfg_a: assert property ($rose(brake_detected_fault) |-> ##[0:2] config_eff == 2'h1)
		else $error("config not promoted");
endmodule
bind hbs_top hbs_top_sva chk_i (.clk, .rst, .force_release_in, .force_apply_in, .brake_config, .brake_out,
	.pulse_enable, .accel_enable, .brake_detected_fault, .config_eff, .brake_status);

// file: tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 4;
	logic clk = 0, rst = 1, on_cmd = 0, force_release_in = 0, force_apply_in = 0, speed_ctrl_enable_in = 0;
	logic first_commission = 0, fault_ack = 0, fitted = 0, brake_present_in, shoe_lifted;
	logic [1:0]  brake_config = 2'h1;
	logic [15:0] brake_release_time = 16'h1, brake_closing_time = 16'h1, standstill_threshold = 16'h0100;
	logic [15:0] standstill_monitor_time = 16'h2, pulse_suppress_delay = 16'h3;
	logic signed [15:0] speed_setpoint = 16'sh0, speed_actual = 16'sh0;
	logic        brake_out, pulse_enable, accel_enable, brake_detected_fault;
	logic [1:0]  config_eff;
	logic [15:0] brake_status;
	int          n_errors = 0, total_checks = 0;
	hbs_top #(.TICK_CYCLES(TK)) dut (.*);
	hbs_brake_model brake_i (.clk, .brake_out, .fitted, .brake_present_in, .shoe_lifted);
	always #5 clk = ~clk;
	// ==========================================================
	// Tasks
	function automatic int span(input logic [15:0] t);
		return (int'(t) + 2) * TK + 6;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_brake(input logic v);
		for (int i = 0; i < 300 && brake_out !== v; i++)
			cyc(1);
		chk(16'(brake_out), 16'(v));
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		void'($urandom(63));
		cyc(6);
		rst = 0;
		chk(brake_status, 16'h0);
		for (int k = 1; k < 4; k += 2) begin
			brake_config = 2'(k);
			brake_release_time = 16'(1 + $urandom % 3);
			brake_closing_time = 16'(1 + $urandom % 3);
			speed_actual = 16'(16'h0200 + $urandom % 256);
			on_cmd = 1;
			speed_ctrl_enable_in = 1;
			wait_brake(1);
			chk(16'(accel_enable), 16'h0);
			cyc(span(brake_release_time));
			chk(16'(accel_enable), 16'h1);
			chk(brake_status, 16'h1000);
			if (k == 3)
				speed_ctrl_enable_in = 0;
			else
				on_cmd = 0;
			speed_actual = 16'($signed(16'($urandom % 255)) - 16'sh7f);
			wait_brake(0);
			chk(16'(pulse_enable), 16'h1);
			cyc(1);
			chk(brake_status, 16'h2000);
			cyc(span(brake_closing_time));
			chk(16'(pulse_enable), 16'h0);
			on_cmd = 0;
			speed_ctrl_enable_in = 0;
			cyc(4);
		end
		on_cmd = 1;
		speed_ctrl_enable_in = 1;
		wait_brake(1);
		force_apply_in = 1;
		wait_brake(0);
		on_cmd = 0;
		speed_ctrl_enable_in = 0;
		force_apply_in = 0;
		cyc(40);
		force_release_in = 1;
		wait_brake(1);
		force_release_in = 0;
		wait_brake(0);
		brake_config = 2'h0;
		force_release_in = 1;
		on_cmd = 1;
		speed_ctrl_enable_in = 1;
		cyc(12);
		chk({15'h0, brake_out}, 16'h0);
		chk({15'h0, pulse_enable}, 16'h1);
		force_release_in = 0;
		on_cmd = 0;
		cyc(12);
		fitted = 1;
		first_commission = 1;
		cyc(10);
		chk({13'h0, config_eff, brake_detected_fault}, 16'h3);
		first_commission = 0;
		fault_ack = 1;
		cyc(10);
		chk({13'h0, config_eff, brake_detected_fault}, 16'h2);
		force_release_in = 1;
		wait_brake(1);
		cyc(1);
		chk(16'(shoe_lifted), 16'h1);
		force_release_in = 0;
		wait_brake(0);
		wrap_up();
	end
	initial begin
		#200000;
		n_errors++;
		wrap_up();
	end
endmodule
